// [hdl/tfs_map.svh]
// Purpose: register offsets, field positions, reset values and threshold maps of the cell scheduler
// Assumes: byte addresses on an 8-bit wishbone address, one 32-bit word per register
// Notes: definitions only
`ifndef TFS_MAP_SVH
`define TFS_MAP_SVH

// ----------------------------------------
// register offsets (byte addresses)
// ----------------------------------------
`define TFS_OFS_RATE0 8'h00
`define TFS_OFS_CGEN0 8'h10
`define TFS_OFS_STATUS 8'h20
`define TFS_OFS_CTRL 8'h24
`define TFS_OFS_BLOCK_MASK 8'hf0

// ----------------------------------------
// field positions
// ----------------------------------------
`define TFS_PRIO_MSB 3
`define TFS_PRIO_LSB 2
`define TFS_CTRL_ENABLE_BIT 0

// ----------------------------------------
// reset values
// ----------------------------------------
`define TFS_RATE_RST 8'h00
`define TFS_CGEN_RST 8'h0c
`define TFS_CTRL_RST 1'b0

// ----------------------------------------
// threshold maps: 3-bit slot bit index per threshold bit, bit 7 source first
// ----------------------------------------
`define TFS_PERM_PORT0 24'h77e888
`define TFS_PERM_PORT1 24'h535647
`define TFS_PERM_PORT2 24'h2ec43e
`define TFS_PERM_PORT3 24'h0a33f5

`endif

// [hdl/tfs_pkg.sv]
// Purpose: shared types of the transmit cell scheduler
// Assumes: four transmit ports, classic wishbone with 8-bit byte address
// Notes: offsets and constants live in tfs_map.svh
package tfs_pkg;

   // ----------------------------------------
   // carriers
   // ----------------------------------------
   typedef struct packed {
      logic cyc;
      logic stb;
      logic we;
      logic [7:0] adr;
      logic [3:0] sel;
      logic [31:0] dat;
   } tfs_wb_req_t;

   typedef struct packed {
      logic [1:0] port;
      logic [7:0] slot;
   } tfs_grant_t;

endpackage

// [hdl/tfs_rate_gate.sv]
// Purpose: per-port rate eligibility from slot number and programmed rate
// Assumes: threshold is a fixed bit permutation of the slot number
// Notes: one instance per port, the permutation is the only difference
`timescale 1ns/1ps
module tfs_rate_gate #(
   parameter logic [23:0] PERM = 24'h000000
) (
   slotNum,
   rate,
   eligible
);
   input wire logic [7:0] slotNum;
   input wire logic [7:0] rate;
   output logic eligible;

   logic [7:0] thresh;

   // ----------------------------------------
   // threshold lookup
   // ----------------------------------------
   // permutation instead of a 256-entry rom: same values, no memory
   genvar gb;
   generate
      for (gb = 0; gb < 8; gb++) begin : g_bit
         assign thresh[gb] = slotNum[PERM[3*gb +: 3]];
      end
   endgenerate

   // zero rate blocks even slot 0, whose threshold is zero
   assign eligible = (rate != 8'h00) && (rate >= thresh);
endmodule

// [hdl/tfs_scheduler.sv]
// Purpose: transmit cell slot scheduler for four fifo ports, rate gate then priority
// Assumes: slotTick pulses once per cell slot; portCellAvail is each port's fifo not-empty
// Notes: grants leave through a two-entry buffer toward the line framer
`timescale 1ns/1ps
`include "tfs_map.svh"

module tfs_scheduler
   import tfs_pkg::*;
(
   input wire logic core_clk,
   input wire logic reset_n,
   input wire tfs_wb_req_t wbReq,
   output logic [31:0] wbDatO,
   output logic wbAck,
   input wire logic slotTick,
   output logic slotAccept,
   input wire logic [3:0] portCellAvail,
   output logic [3:0] portGrant,
   output tfs_grant_t grantData,
   output logic grantValid,
   input wire logic grantReady
);

   // ----------------------------------------
   // declarations
   // ----------------------------------------
   logic [7:0] rate_ff [4];
   logic [7:0] cgen_ff [4];
   logic enable_ff;
   logic [7:0] slotCount_ff;
   logic [1:0] lastPort_ff;
   logic [3:0] portGrant_ff;
   tfs_grant_t buf0_ff;
   tfs_grant_t buf1_ff;
   logic [1:0] bufCnt_ff;
   logic wbAck_ff;
   logic [31:0] wbDat_ff;

   logic wbHit;
   logic wbWrite;
   logic [1:0] regIdx;
   logic [7:0] blockAdr;
   logic [7:0] wordAdr;
   logic [31:0] nxt_wbDat;
   logic [3:0] elig;
   logic [3:0] candVec;
   logic [3:0] atBest;
   logic [1:0] prio [4];
   logic [1:0] bestLvl;
   logic [1:0] lowestLvl;
   logic anyCand;
   logic [1:0] winIdx;
   logic decide;
   logic push;
   logic pop;
   logic bufInReady;
   tfs_grant_t nxt_entry;
   logic [3:0] rateZero;
   logic [3:0] rateFull;

   // ----------------------------------------
   // wishbone slave
   // ----------------------------------------
   assign wbHit = wbReq.cyc && wbReq.stb && !wbAck_ff;
   assign wbWrite = wbHit && wbReq.we && wbReq.sel[0];
   assign regIdx = wbReq.adr[3:2];
   // registers are word aligned, the two low address bits are ignored
   assign wordAdr = {wbReq.adr[7:2], 2'b00};
   assign blockAdr = wordAdr & `TFS_OFS_BLOCK_MASK;

   // one wait state, ack drops the cycle after it was given
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         wbAck_ff <= 1'b0;
      end else begin
         wbAck_ff <= wbHit;
      end
   end

   // settings take effect at the clock edge of the write, mid-slot included; no guard against change while busy
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         for (int i = 0; i < 4; i++) begin
            rate_ff[i] <= `TFS_RATE_RST;
            cgen_ff[i] <= `TFS_CGEN_RST;
         end
      end else if (wbWrite) begin
         if (blockAdr == `TFS_OFS_RATE0) begin
            rate_ff[regIdx] <= wbReq.dat[7:0];
         end else if (blockAdr == `TFS_OFS_CGEN0) begin
            cgen_ff[regIdx] <= wbReq.dat[7:0];
         end
      end
   end

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         enable_ff <= `TFS_CTRL_RST;
      end else if (wbWrite && wordAdr == `TFS_OFS_CTRL) begin
         enable_ff <= wbReq.dat[`TFS_CTRL_ENABLE_BIT];
      end
   end

   always_comb begin
      nxt_wbDat = 32'h00000000;
      if (blockAdr == `TFS_OFS_RATE0) begin
         nxt_wbDat = {24'h000000, rate_ff[regIdx]};
      end else if (blockAdr == `TFS_OFS_CGEN0) begin
         nxt_wbDat = {24'h000000, cgen_ff[regIdx]};
      end else if (wordAdr == `TFS_OFS_STATUS) begin
         nxt_wbDat = {20'h00000, bufCnt_ff, lastPort_ff, slotCount_ff};
      end else if (wordAdr == `TFS_OFS_CTRL) begin
         nxt_wbDat = {31'h00000000, enable_ff};
      end
   end

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         wbDat_ff <= 32'h00000000;
      end else if (wbHit) begin
         wbDat_ff <= nxt_wbDat;
      end
   end

   assign wbAck = wbAck_ff;
   assign wbDatO = wbDat_ff;

   // ----------------------------------------
   // slot counter
   // ----------------------------------------
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         slotCount_ff <= 8'h00;
      end else if (slotTick) begin
         slotCount_ff <= slotCount_ff + 8'h01;
      end
   end

   // ----------------------------------------
   // rate gates
   // ----------------------------------------
   // one gate per port, only the permutation differs
   tfs_rate_gate #(.PERM(`TFS_PERM_PORT0)) i_tfs_rate_gate0 (
      .slotNum(slotCount_ff),
      .rate(rate_ff[0]),
      .eligible(elig[0])
   );
   tfs_rate_gate #(.PERM(`TFS_PERM_PORT1)) i_tfs_rate_gate1 (
      .slotNum(slotCount_ff),
      .rate(rate_ff[1]),
      .eligible(elig[1])
   );
   tfs_rate_gate #(.PERM(`TFS_PERM_PORT2)) i_tfs_rate_gate2 (
      .slotNum(slotCount_ff),
      .rate(rate_ff[2]),
      .eligible(elig[2])
   );
   tfs_rate_gate #(.PERM(`TFS_PERM_PORT3)) i_tfs_rate_gate3 (
      .slotNum(slotCount_ff),
      .rate(rate_ff[3]),
      .eligible(elig[3])
   );

   // rate first, priority after; the rate is a ceiling only
   assign candVec = enable_ff ? (portCellAvail & elig) : 4'h0;

   // ----------------------------------------
   // priority selection
   // ----------------------------------------
   always_comb begin
      bestLvl = 2'h3;
      lowestLvl = 2'h0;
      anyCand = 1'b0;
      for (int i = 0; i < 4; i++) begin
         prio[i] = cgen_ff[i][`TFS_PRIO_MSB:`TFS_PRIO_LSB];
         if (prio[i] > lowestLvl) begin
            lowestLvl = prio[i];
         end
         if (candVec[i] && prio[i] <= bestLvl) begin
            bestLvl = prio[i];
         end
         anyCand = anyCand | candVec[i];
      end
      for (int i = 0; i < 4; i++) begin
         atBest[i] = candVec[i] && (prio[i] == bestLvl);
      end
   end

   // one winner only; higher levels hold their last winner, lowest level rotates
   always_comb begin
      winIdx = 2'h0;
      if (bestLvl == lowestLvl) begin
         // search from the port after the last winner, nearest hit assigned last
         for (int k = 4; k >= 1; k--) begin
            if (atBest[lastPort_ff + 2'(k)]) begin
               winIdx = lastPort_ff + 2'(k);
            end
         end
      end else if (atBest[lastPort_ff]) begin
         winIdx = lastPort_ff;
      end else begin
         for (int i = 3; i >= 0; i--) begin
            if (atBest[i]) begin
               winIdx = 2'(i);
            end
         end
      end
   end

   // a slot that meets a full buffer picks nobody, so no grant is dropped
   assign decide = slotTick && bufInReady;
   assign push = decide && anyCand;
   assign slotAccept = bufInReady;

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         lastPort_ff <= 2'h3;
      end else if (push) begin
         lastPort_ff <= winIdx;
      end
   end

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         portGrant_ff <= 4'h0;
      end else begin
         portGrant_ff <= push ? (4'h1 << winIdx) : 4'h0;
      end
   end

   assign portGrant = portGrant_ff;

   // ----------------------------------------
   // two-entry grant buffer
   // ----------------------------------------
   assign bufInReady = (bufCnt_ff != 2'h2);
   assign pop = grantValid && grantReady;
   assign nxt_entry.port = winIdx;
   assign nxt_entry.slot = slotCount_ff;

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         buf0_ff <= '0;
         buf1_ff <= '0;
         bufCnt_ff <= 2'h0;
      end else begin
         unique case ({push, pop})
            2'b10: begin
               if (bufCnt_ff == 2'h0) begin
                  buf0_ff <= nxt_entry;
               end else begin
                  buf1_ff <= nxt_entry;
               end
               bufCnt_ff <= bufCnt_ff + 2'h1;
            end
            2'b01: begin
               buf0_ff <= buf1_ff;
               bufCnt_ff <= bufCnt_ff - 2'h1;
            end
            2'b11: begin
               if (bufCnt_ff == 2'h1) begin
                  buf0_ff <= nxt_entry;
               end else begin
                  buf0_ff <= buf1_ff;
                  buf1_ff <= nxt_entry;
               end
            end
            2'b00: begin
            end
         endcase
      end
   end

   assign grantValid = (bufCnt_ff != 2'h0);
   assign grantData = buf0_ff;

   // ----------------------------------------
   // checks
   // ----------------------------------------
   // rate extremes per port, checked here since the gates have no clock
   always_comb begin
      for (int i = 0; i < 4; i++) begin
         rateZero[i] = (rate_ff[i] == 8'h00);
         rateFull[i] = (rate_ff[i] == 8'hff);
      end
   end

   a_zero_rate_block: assert property (@(posedge core_clk) disable iff (!reset_n)
      (elig & rateZero) == 4'h0) else $error("zero rate port found eligible");
   a_full_rate_pass: assert property (@(posedge core_clk) disable iff (!reset_n)
      (elig & rateFull) == rateFull) else $error("full rate port found ineligible");
   a_single_grant: assert property (@(posedge core_clk) disable iff (!reset_n)
      $onehot0(portGrant_ff)) else $error("more than one port granted");
   a_grant_from_cand: assert property (@(posedge core_clk) disable iff (!reset_n)
      push |=> $onehot(portGrant_ff) && ((portGrant_ff & $past(candVec)) == portGrant_ff))
      else $error("grant went to a port that was not a candidate");
   a_idle_no_grant: assert property (@(posedge core_clk) disable iff (!reset_n)
      (slotTick && !anyCand) |=> (portGrant_ff == 4'h0)) else $error("grant without eligible port");
   a_prio_order: assert property (@(posedge core_clk) disable iff (!reset_n)
      push |-> (prio[winIdx] == bestLvl) && candVec[winIdx]) else $error("winner not at best level");
   a_top_holds: assert property (@(posedge core_clk) disable iff (!reset_n)
      (push && bestLvl != lowestLvl && atBest[lastPort_ff]) |=> portGrant_ff[$past(lastPort_ff)])
      else $error("holding port lost its slot");
   a_rr_rotates: assert property (@(posedge core_clk) disable iff (!reset_n)
      (push && bestLvl == lowestLvl && $countones(atBest) > 1) |-> (winIdx != lastPort_ff))
      else $error("round robin repeated a port");
   a_slot_wraps: assert property (@(posedge core_clk) disable iff (!reset_n)
      (slotTick && slotCount_ff == 8'hff) |=> (slotCount_ff == 8'h00)) else $error("slot counter did not wrap");
   a_buf_stalls: assert property (@(posedge core_clk) disable iff (!reset_n)
      (grantValid && !grantReady) |=> grantValid && $stable(grantData)) else $error("stalled grant changed");
   a_wb_acks: assert property (@(posedge core_clk) disable iff (!reset_n)
      wbHit |=> wbAck ##1 !wbAck) else $error("wishbone ack not one cycle after request");
   a_full_skips: assert property (@(posedge core_clk) disable iff (!reset_n)
      (slotTick && !slotAccept) |=> (portGrant_ff == 4'h0)) else $error("grant issued into a full buffer");
   a_grant_queued: assert property (@(posedge core_clk) disable iff (!reset_n)
      push |=> grantValid) else $error("granted cell missing from buffer");
   a_buf_bounded: assert property (@(posedge core_clk) disable iff (!reset_n)
      bufCnt_ff != 2'h3) else $error("grant buffer count out of range");

   c_buf_full: cover property (@(posedge core_clk) disable iff (!reset_n) bufCnt_ff == 2'h2 && !grantReady);
   c_push_pop: cover property (@(posedge core_clk) disable iff (!reset_n) push && pop);
   c_rr_turn: cover property (@(posedge core_clk) disable iff (!reset_n)
      push && bestLvl == lowestLvl && $countones(atBest) > 1);
   c_top_hold: cover property (@(posedge core_clk) disable iff (!reset_n) push && bestLvl != lowestLvl);
   c_slot_wrap: cover property (@(posedge core_clk) disable iff (!reset_n) slotTick && slotCount_ff == 8'hff);
endmodule

// [tb/tb_top.sv]
// Purpose: self-checking bench of the transmit cell scheduler
// Assumes: fifo model on the port side, bench plays wishbone master and line side
// Notes: settings change only while every fifo model count is zero
`timescale 1ns/1ps
`include "tfs_map.svh"
module tb_top import tfs_pkg::*; ;
   // ----------------------------------------
   // signals and instances
   // ----------------------------------------
   logic core_clk = 1'b0;
   logic reset_n = 1'b0;
   tfs_wb_req_t wbReq;
   logic [31:0] wbDatO;
   logic wbAck, slotTick, slotAccept, grantValid, grantReady, loadEn;
   logic [3:0] portCellAvail, portGrant;
   tfs_grant_t grantData;
   logic [1:0] loadPort;
   logic [7:0] loadCnt, slotNo;
   int errCount, comparisons, cycles;

   tfs_scheduler i_tfs_scheduler (.core_clk(core_clk), .reset_n(reset_n), .wbReq(wbReq), .wbDatO(wbDatO),
      .wbAck(wbAck), .slotTick(slotTick), .slotAccept(slotAccept), .portCellAvail(portCellAvail),
      .portGrant(portGrant), .grantData(grantData), .grantValid(grantValid), .grantReady(grantReady));
   tfs_fifo_model i_tfs_fifo_model (.core_clk(core_clk), .reset_n(reset_n), .portGrant(portGrant),
      .loadEn(loadEn), .loadPort(loadPort), .loadCnt(loadCnt), .portCellAvail(portCellAvail));

   initial begin
      forever #4 core_clk = ~core_clk;
   end

   // ----------------------------------------
   // shared tasks
   // ----------------------------------------
   task automatic close_out();
      $display("comparisons %0d mismatches %0d", comparisons, errCount);
      if (errCount == 0 && comparisons > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   // hang guard, far above the several hundred cycles the run needs
   always @(posedge core_clk) begin
      cycles = cycles + 1;
      if (cycles == 4000) begin
         errCount++;
         close_out();
      end
   end

   task automatic chk_reg(input string what, input logic [31:0] exp, input logic [31:0] got);
      comparisons++;
      if (got !== exp) begin
         errCount++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic chk_grant(input string what, input logic [13:0] exp, input logic [13:0] got);
      comparisons++;
      if (got !== exp) begin
         errCount++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat, output logic [31:0] rd);
      @(posedge core_clk);
      wbReq <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: 4'hf, dat: dat};
      do @(posedge core_clk); while (wbAck !== 1'b1);
      rd = wbDatO;
      wbReq <= '0;
   endtask

   task automatic wr(input logic [7:0] adr, input logic [31:0] dat);
      logic [31:0] rd;
      wb(1'b1, adr, dat, rd);
   endtask

   task automatic rdchk(input string what, input logic [7:0] adr, input logic [31:0] exp);
      logic [31:0] rd;
      wb(1'b0, adr, 32'h0000_0000, rd);
      chk_reg(what, exp, rd);
   endtask

   task automatic load(input logic [1:0] p, input logic [7:0] n);
      @(posedge core_clk);
      loadEn <= 1'b1;
      loadPort <= p;
      loadCnt <= n;
      @(posedge core_clk);
      loadEn <= 1'b0;
   endtask

   // one slot: grant pulse looked at in the cycle after the deciding edge
   task automatic tick(input logic [3:0] exp);
      logic [1:0] p;
      @(posedge core_clk);
      slotTick <= 1'b1;
      @(posedge core_clk);
      slotTick <= 1'b0;
      #1;
      p = exp[3] ? 2'd3 : exp[2] ? 2'd2 : exp[1] ? 2'd1 : 2'd0;
      if (exp != 4'h0 && grantReady) begin
         chk_grant("grant", {exp, p, slotNo}, {portGrant, grantData.port, grantData.slot});
      end else begin
         chk_grant("grant", {exp, 10'h000}, {portGrant, 10'h000});
      end
      slotNo = slotNo + 8'h01;
   endtask

   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task automatic t_regs();
      for (int i = 0; i < 4; i++) begin
         rdchk("rate", `TFS_OFS_RATE0 + 8'(4 * i), {24'h000000, `TFS_RATE_RST});
         rdchk("cgen", `TFS_OFS_CGEN0 + 8'(4 * i), {24'h000000, `TFS_CGEN_RST});
      end
      rdchk("status", `TFS_OFS_STATUS, 32'h0000_0300);
      rdchk("ctrl", `TFS_OFS_CTRL, 32'h0000_0000);
      wr(`TFS_OFS_RATE0 + 8'h04, 32'hffff_ff5a);
      rdchk("rate1", `TFS_OFS_RATE0 + 8'h04, 32'h0000_005a);
      wr(`TFS_OFS_RATE0 + 8'h04, 32'h0000_0000);
      wr(8'h28, 32'h0000_0077);
      rdchk("unmapped", 8'h28, 32'h0000_0000);
   endtask

   task automatic t_burst();
      wr(`TFS_OFS_CTRL, 32'h0000_0001);
      wr(`TFS_OFS_RATE0, 32'h0000_007f); // all fifos empty meanwhile
      wr(`TFS_OFS_RATE0 + 8'h0c, 32'h0000_007f);
      load(2'd0, 8'd40);
      for (int i = 0; i < 16; i++) tick(i < 8 ? 4'h1 : 4'h0);
      load(2'd0, 8'd0);
      load(2'd3, 8'd40);
      for (int i = 0; i < 16; i++) tick(i % 2 == 0 ? 4'h8 : 4'h0);
      load(2'd3, 8'd0);
   endtask

   task automatic t_rate();
      load(2'd1, 8'd4);
      repeat (4) tick(4'h0);
      load(2'd1, 8'd0);
      wr(`TFS_OFS_RATE0 + 8'h04, 32'h0000_00ff);
      load(2'd1, 8'd4);
      repeat (4) tick(4'h2);
   endtask

   task automatic t_prio();
      wr(`TFS_OFS_CGEN0, 32'h0000_0000);
      wr(`TFS_OFS_RATE0, 32'h0000_00ff);
      wr(`TFS_OFS_RATE0 + 8'h08, 32'h0000_00ff);
      load(2'd1, 8'd3);
      load(2'd2, 8'd3);
      tick(4'h4);
      tick(4'h2);
      load(2'd0, 8'd2);
      tick(4'h1);
      tick(4'h1);
      tick(4'h2);
      tick(4'h4);
      tick(4'h2);
      tick(4'h4);
   endtask

   task automatic t_stall();
      logic [7:0] s;
      @(posedge core_clk);
      grantReady <= 1'b0;
      load(2'd2, 8'd5);
      s = slotNo;
      tick(4'h4);
      tick(4'h4);
      chk_reg("slotAccept", 32'h0000_0000, {31'h0, slotAccept});
      rdchk("status", `TFS_OFS_STATUS, {20'h00000, 2'd2, 2'd2, s + 8'd2});
      tick(4'h0);
      @(posedge core_clk);
      grantReady <= 1'b1;
      #1 chk_grant("head", {4'h0, 2'd2, s}, {4'h0, grantData.port, grantData.slot});
      @(posedge core_clk);
      #1 chk_grant("next", {4'h0, 2'd2, s + 8'd1}, {4'h0, grantData.port, grantData.slot});
      @(posedge core_clk);
      #1 chk_reg("grantValid", 32'h0000_0000, {31'h0, grantValid});
      load(2'd2, 8'd0);
   endtask

   task automatic t_wrap();
      while (slotNo != 8'hff) tick(4'h0);
      load(2'd1, 8'd2);
      tick(4'h2);
      tick(4'h2);
      rdchk("status", `TFS_OFS_STATUS, {20'h00000, 2'd0, 2'd1, 8'h01});
      wr(`TFS_OFS_CTRL, 32'h0000_0000);
      load(2'd1, 8'd2);
      tick(4'h0);
      load(2'd1, 8'd0);
   endtask

   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial begin
      wbReq = '0;
      slotTick = 1'b0;
      grantReady = 1'b1;
      loadEn = 1'b0;
      loadPort = 2'd0;
      loadCnt = 8'h00;
      slotNo = 8'h00;
      errCount = 0;
      comparisons = 0;
      cycles = 0;
      repeat (4) @(posedge core_clk);
      reset_n <= 1'b1;
      t_regs();
      t_burst();
      t_rate();
      t_prio();
      t_stall();
      t_wrap();
      close_out();
   end
endmodule

// [tb/tfs_fifo_model.sv]
// Purpose: system-side transmit fifo ports feeding the cell scheduler
// Assumes: one cell leaves a port for each one-hot grant pulse
// Notes: cell counts are loaded by the bench, a count of zero is an empty fifo
`timescale 1ns/1ps
module tfs_fifo_model (
   input wire logic core_clk,
   input wire logic reset_n,
   input wire logic [3:0] portGrant,
   input wire logic loadEn,
   input wire logic [1:0] loadPort,
   input wire logic [7:0] loadCnt,
   output logic [3:0] portCellAvail
);
   // ----------------------------------------
   // cell counts
   // ----------------------------------------
   logic [7:0] cellCnt_ff [4];

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         for (int i = 0; i < 4; i++) cellCnt_ff[i] <= 8'h00;
      end else begin
         for (int i = 0; i < 4; i++) begin
            if (loadEn && loadPort == i[1:0]) begin
               cellCnt_ff[i] <= loadCnt;
            end else if (portGrant[i] && cellCnt_ff[i] != 8'h00) begin
               cellCnt_ff[i] <= cellCnt_ff[i] - 8'h01;
            end
         end
      end
   end

   // empty flag held while nothing queued, the only safe time for new settings
   always_comb begin
      for (int i = 0; i < 4; i++) portCellAvail[i] = (cellCnt_ff[i] != 8'h00);
   end
endmodule
